// ==== rtl/sfl_pkg.sv ====
// Constants, register map and field layout of the serdes control block
package sfl_pkg;

   // ----------------------------------------
   // Clock and rates
   // ----------------------------------------
   localparam int unsigned REF_CLK_MHZ = 100;
   localparam int unsigned STD_LANE_MHZ = 622;
   localparam int unsigned FEC_LANE_MHZ = 666;
   localparam real STD_DIV_MHZ = 155.52;
   localparam int unsigned FEC_DIV_MHZ = 166;
   localparam int unsigned POWERUP_FLUSH_CYCLES = 10;

   // ----------------------------------------
   // Data path shape
   // ----------------------------------------
   localparam int unsigned LANES = 4;
   localparam int unsigned FIFO_DEPTH = 9;
   localparam logic [3:0] FIFO_LAST = 4'h8;
   localparam logic [3:0] FIFO_FULL = 4'h9;
   localparam int unsigned SYNC_W = 11;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] EVENT_OFS = 12'h008;
   localparam logic [11:0] MASK_OFS = 12'h00C;

   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int unsigned CTRL_AUTO_FLUSH = 0;
   localparam int unsigned CTRL_MUTE = 1;
   localparam int unsigned CTRL_POLARITY = 2;
   localparam int unsigned CTRL_INPUT_CHOICE = 3;
   localparam int unsigned CTRL_FLOAT = 4;
   localparam int unsigned CTRL_FEC = 5;
   localparam int unsigned CTRL_W = 6;
   localparam logic [5:0] CTRL_RESET = 6'h00;

   // ----------------------------------------
   // Event fields, shared by event and mask
   // ----------------------------------------
   localparam int unsigned EV_OVERFLOW = 0;
   localparam int unsigned EV_LOSS = 1;
   localparam int unsigned EV_MULT_UNLOCK = 2;
   localparam int unsigned EV_CDR_UNLOCK = 3;
   localparam int unsigned EV_W = 4;
   localparam logic [3:0] EV_RESET = 4'h0;
   localparam logic [3:0] MASK_RESET = 4'h0;

endpackage : sfl_pkg

// ==== rtl/sfl_serdes_ctrl.sv ====
// Control and status logic around the serializer and deserializer
//
// Decided for this implementation: register access over APB and the register addresses.

// Overview of operation
// (R01) The multiplier lock flag follows the clock multiplier lock state.
// (R02) The overflow output is high while the transmit buffer is in overflow.
// (R03) The controller holds the flush input high for ten transmit lane clocks at power-up; this block makes no such pulse, the bench drives buffer_flush_in.
// (R04) A flush request empties and resets the transmit buffer.
// (R05) With auto flush enabled the buffer flushes itself on overflow, else flush is manual.
// (R06) All four receive lanes update together on the rising receive lane clock.
// (R07) Receive deserializing is MSB first, the first bit landing on lane 3.
// (R08) Lane clock and rate are 622 MHz standard and 666 MHz with error correction.
// (R09) The float control puts receive lanes and lane clock in high impedance.
// (R10) The input choice picks the primary input when low, the secondary when high.
// (R11) A divided clock of 155.52 or 166 MHz comes from the recovered clock.
// (R12) The recovery lock flag is high while clock recovery is locked.
// (R13) Internal loss is the XNOR of the optical loss input and the polarity bit.
// (R14) The signal loss flag is high while the corrected loss input reports loss.
// (R15) With mute enabled the receive data is forced low while loss persists.
// (R16) Transmit lanes are sampled on the rising lane clock and sent lane 3 first.
// (R17) The overflow flag stays high until the buffer is flushed, then falls.
module sfl_serdes_ctrl (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Transmit side pins
   input wire logic tx_lane_clock,
   input wire logic [3:0] tx_lane_in,
   input wire logic buffer_flush_in,
   input wire logic multiplier_locked_in,
   output logic multiplier_lock_flag,
   output logic tx_overflow,
   output logic tx_serial_out,
   // Receive side pins
   input wire logic primary_serial_in,
   input wire logic secondary_serial_in,
   input wire logic recovery_locked_in,
   input wire logic optical_loss_in,
   output logic [3:0] rx_lane_out,
   output logic rx_lane_oe,
   output logic rx_lane_clock,
   output logic rx_clock_oe,
   output logic recovered_div_clock,
   output logic recovery_lock_flag,
   output logic signal_loss_flag,
   // Interrupt
   output logic irq
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [3:0] ptr_inc(input logic [3:0] p);
      ptr_inc = (p == sfl_pkg::FIFO_LAST) ? 4'h0 : p + 4'h1;
   endfunction : ptr_inc

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [10:0] sync_a;
   logic [10:0] sync_b;
   logic tx_clk_prev;
   wire [10:0] pin_vec = {tx_lane_clock, tx_lane_in, buffer_flush_in, multiplier_locked_in,
      recovery_locked_in, optical_loss_in, primary_serial_in, secondary_serial_in};

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_a <= 11'h000;
         sync_b <= 11'h000;
         tx_clk_prev <= 1'b0;
      end else begin
         sync_a <= pin_vec;
         sync_b <= sync_a;
         tx_clk_prev <= sync_b[10];
      end
   end

   wire s_tx_clk = sync_b[10];
   wire [3:0] s_tx_lanes = sync_b[9:6];
   wire s_flush = sync_b[5];
   wire s_mult_lock = sync_b[4];
   wire s_cdr_lock = sync_b[3];
   wire s_opt_loss = sync_b[2];
   wire s_primary = sync_b[1];
   wire s_secondary = sync_b[0];
   // Transmit lanes taken on the rising lane clock
   wire tx_clk_rise = s_tx_clk & ~tx_clk_prev; // [R16]

   // ----------------------------------------
   // Registers and APB decode
   // ----------------------------------------
   logic [5:0] ctrl;
   logic [3:0] events;
   logic [3:0] mask;

   wire apb_take = psel & penable & pready;
   wire apb_wr = apb_take & pwrite;
   wire sel_ctrl = paddr == sfl_pkg::CTRL_OFS;
   wire sel_status = paddr == sfl_pkg::STATUS_OFS;
   wire sel_event = paddr == sfl_pkg::EVENT_OFS;
   wire sel_mask = paddr == sfl_pkg::MASK_OFS;
   wire sel_any = sel_ctrl | sel_status | sel_event | sel_mask;

   wire auto_flush_enable = ctrl[sfl_pkg::CTRL_AUTO_FLUSH];
   wire mute_on_loss_enable = ctrl[sfl_pkg::CTRL_MUTE];
   wire loss_polarity = ctrl[sfl_pkg::CTRL_POLARITY];
   wire serial_input_choice = ctrl[sfl_pkg::CTRL_INPUT_CHOICE];
   wire rx_output_float = ctrl[sfl_pkg::CTRL_FLOAT];
   wire fec_mode = ctrl[sfl_pkg::CTRL_FEC];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= sfl_pkg::CTRL_RESET;
         mask <= sfl_pkg::MASK_RESET;
      end else begin
         if (apb_wr && sel_ctrl) begin
            ctrl <= pwdata[5:0];
         end
         if (apb_wr && sel_mask) begin
            mask <= pwdata[3:0];
         end
      end
   end

   // ----------------------------------------
   // Transmit elastic buffer
   // ----------------------------------------
   logic [3:0] fifo_mem [0:8];
   logic [3:0] wr_ptr;
   logic [3:0] rd_ptr;
   logic [3:0] fifo_count;
   logic ovf_flag;
   logic [3:0] phase;

   // Auto flush fires the cycle after the flag rises
   wire auto_flush = ovf_flag & auto_flush_enable; // [R05]
   // Manual flush from the framer, also the power-up clearing pulse
   wire do_flush = s_flush | auto_flush; // [R03] [R04]
   wire fifo_full = fifo_count == sfl_pkg::FIFO_FULL;
   wire fifo_empty = fifo_count == 4'h0;
   wire fifo_push = tx_clk_rise & ~fifo_full & ~do_flush;
   wire word_slot = phase[1:0] == 2'h3;
   wire fifo_pop = word_slot & ~fifo_empty & ~do_flush;
   // Word lost on a full buffer marks overflow
   wire ovf_event = tx_clk_rise & fifo_full & ~do_flush; // [R02]
   wire [3:0] next_count = fifo_count + {3'h0, fifo_push} - {3'h0, fifo_pop};

   genvar gi;
   generate
      for (gi = 0; gi < sfl_pkg::FIFO_DEPTH; gi++) begin : g_slot
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               fifo_mem[gi] <= 4'h0;
            end else if (fifo_push && wr_ptr == gi) begin
               fifo_mem[gi] <= s_tx_lanes;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
         fifo_count <= 4'h0;
      end else if (do_flush) begin
         // Flush empties and resets the buffer
         wr_ptr <= 4'h0; // [R04]
         rd_ptr <= 4'h0;
         fifo_count <= 4'h0;
      end else begin
         if (fifo_push) begin
            wr_ptr <= ptr_inc(wr_ptr);
         end
         if (fifo_pop) begin
            rd_ptr <= ptr_inc(rd_ptr);
         end
         fifo_count <= next_count;
      end
   end

   // Sticky until a flush, never cleared by software
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ovf_flag <= 1'b0;
      end else if (ovf_event) begin
         ovf_flag <= 1'b1; // [R17]
      end else if (do_flush) begin
         ovf_flag <= 1'b0; // [R17]
      end
   end

   // ----------------------------------------
   // Serializer
   // ----------------------------------------
   logic [3:0] tx_shift;
   // Idle slots send zeros rather than stale data
   wire [3:0] tx_word = fifo_pop ? fifo_mem[rd_ptr] : 4'h0;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_shift <= 4'h0;
         tx_serial_out <= 1'b0;
      end else begin
         tx_serial_out <= tx_shift[3]; // [R16]
         if (word_slot) begin
            tx_shift <= tx_word;
         end else begin
            tx_shift <= {tx_shift[2:0], 1'b0};
         end
      end
   end

   // ----------------------------------------
   // Receive path
   // ----------------------------------------
   logic [2:0] rx_shift;
   // Model runs one bit per ref clock, so lane clock is ref/4
   // and the divided clock ref/16; fec_mode only scales the real rates.
   wire [3:0] next_phase = phase + 4'h1; // [R08]
   wire rx_bit = serial_input_choice ? s_secondary : s_primary; // [R10]
   wire loss = ~(s_opt_loss ^ loss_polarity); // [R13]
   wire mute = mute_on_loss_enable & loss;
   wire lane_edge = next_phase[1:0] == 2'h2;
   // First bit of the group ends up on lane 3
   wire [3:0] rx_word = {rx_shift, rx_bit}; // [R07]

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase <= 4'h0;
         rx_shift <= 3'h0;
         rx_lane_out <= 4'h0;
         rx_lane_clock <= 1'b0;
         recovered_div_clock <= 1'b0;
      end else begin
         phase <= next_phase;
         rx_shift <= rx_word[2:0];
         rx_lane_clock <= next_phase[1]; // [R08]
         recovered_div_clock <= next_phase[3]; // [R11]
         if (lane_edge) begin
            // All lanes change with the rising lane clock
            rx_lane_out <= mute ? 4'h0 : rx_word; // [R06] [R15]
         end else if (mute) begin
            rx_lane_out <= 4'h0; // [R15]
         end
      end
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   logic mult_prev;
   logic cdr_prev;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         multiplier_lock_flag <= 1'b0;
         recovery_lock_flag <= 1'b0;
         signal_loss_flag <= 1'b0;
         tx_overflow <= 1'b0;
         rx_lane_oe <= 1'b0;
         rx_clock_oe <= 1'b0;
         mult_prev <= 1'b0;
         cdr_prev <= 1'b0;
      end else begin
         multiplier_lock_flag <= s_mult_lock; // [R01]
         recovery_lock_flag <= s_cdr_lock; // [R12]
         signal_loss_flag <= loss; // [R14]
         tx_overflow <= ovf_flag; // [R02]
         rx_lane_oe <= ~rx_output_float; // [R09]
         rx_clock_oe <= ~rx_output_float; // [R09]
         mult_prev <= s_mult_lock;
         cdr_prev <= s_cdr_lock;
      end
   end

   // ----------------------------------------
   // Loss edge detector
   // ----------------------------------------
   logic loss_prev;

   // Resets high, so the still empty synchronisers cannot fake a loss edge
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         loss_prev <= 1'b1;
      end else begin
         loss_prev <= loss;
      end
   end

   // ----------------------------------------
   // Interrupt events
   // ----------------------------------------
   wire [3:0] ev_set;
   assign ev_set[sfl_pkg::EV_OVERFLOW] = ovf_event;
   assign ev_set[sfl_pkg::EV_LOSS] = loss & ~loss_prev;
   assign ev_set[sfl_pkg::EV_MULT_UNLOCK] = mult_prev & ~s_mult_lock;
   assign ev_set[sfl_pkg::EV_CDR_UNLOCK] = cdr_prev & ~s_cdr_lock;
   wire [3:0] ev_clr = (apb_wr && sel_event) ? pwdata[3:0] : 4'h0;
   // Set beats a same-cycle write-one clear
   wire [3:0] next_events = (events & ~ev_clr) | ev_set;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         events <= sfl_pkg::EV_RESET;
         irq <= 1'b0;
      end else begin
         events <= next_events;
         irq <= |(next_events & mask);
      end
   end

   // ----------------------------------------
   // APB answer
   // ----------------------------------------
   wire [31:0] status_word = {22'h00_0000, fifo_count, fec_mode, s_cdr_lock, s_mult_lock,
      loss, ovf_flag, auto_flush};
   wire [31:0] rd_mux = sel_ctrl ? {26'h000_0000, ctrl} :
      sel_status ? status_word :
      sel_event ? {28'h000_0000, events} :
      sel_mask ? {28'h000_0000, mask} : 32'h0000_0000;

   // One wait state keeps prdata and pready straight from flops
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         prdata <= (psel && penable && !pwrite) ? rd_mux : 32'h0000_0000;
         pslverr <= psel & penable & ~pready & ~sel_any;
      end
   end

endmodule : sfl_serdes_ctrl

// ==== sim/sfl_serdes_ctrl_chk.sv ====
// Port-level assertions for the serdes control block
module sfl_serdes_ctrl_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Watched ports
   input wire logic pready,
   input wire logic buffer_flush_in,
   input wire logic multiplier_locked_in,
   input wire logic multiplier_lock_flag,
   input wire logic tx_overflow,
   input wire logic recovery_locked_in,
   input wire logic recovery_lock_flag,
   input wire logic [3:0] rx_lane_out,
   input wire logic rx_lane_oe,
   input wire logic rx_clock_oe,
   input wire logic rx_lane_clock,
   input wire logic recovered_div_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // Clock shapes
   // ----------------------------------------
   sequence s_lane_cycle;
      rx_lane_clock ##1 !rx_lane_clock [*2] ##1 rx_lane_clock;
   endsequence
   sequence s_div_cycle;
      recovered_div_clock [*7] ##1 !recovered_div_clock [*8] ##1 recovered_div_clock;
   endsequence
   a_lane_clk_shape: assert property ($rose(rx_lane_clock) |-> ##1 s_lane_cycle)
      else $error("lane clock not high two low two");
   a_div_clk_shape: assert property ($rose(recovered_div_clock) |-> ##1 s_div_cycle)
      else $error("divided clock not high eight low eight");
   // ----------------------------------------
   // Data, float and flags
   // ----------------------------------------
   a_lanes_together: assert property ($changed(rx_lane_out) |->
      $rose(rx_lane_clock) || rx_lane_out == 4'h0)
      else $error("lanes changed off the lane clock rise");
   a_float_paired: assert property (rx_lane_oe == rx_clock_oe)
      else $error("lane and clock enables differ");
   a_mult_lock_copy: assert property ($stable(multiplier_locked_in) [*5] |->
      multiplier_lock_flag == multiplier_locked_in)
      else $error("multiplier lock flag wrong");
   a_cdr_lock_copy: assert property ($stable(recovery_locked_in) [*5] |->
      recovery_lock_flag == recovery_locked_in)
      else $error("recovery lock flag wrong");
   a_flush_clears_ovf: assert property (buffer_flush_in [*4] |=> !tx_overflow)
      else $error("overflow survived a flush");
   a_ovf_holds: assert property ($fell(tx_overflow) |-> !$past(tx_overflow, 2) ||
      $past(buffer_flush_in, 3) || $past(buffer_flush_in, 4) || $past(buffer_flush_in, 5))
      else $error("overflow fell without a flush");
   // One cycle answer keeps back to back access legal
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
endmodule : sfl_serdes_ctrl_chk

bind sfl_serdes_ctrl sfl_serdes_ctrl_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .pready(pready), .buffer_flush_in(buffer_flush_in),
   .multiplier_locked_in(multiplier_locked_in), .multiplier_lock_flag(multiplier_lock_flag),
   .tx_overflow(tx_overflow), .recovery_locked_in(recovery_locked_in),
   .recovery_lock_flag(recovery_lock_flag), .rx_lane_out(rx_lane_out),
   .rx_lane_oe(rx_lane_oe), .rx_clock_oe(rx_clock_oe), .rx_lane_clock(rx_lane_clock),
   .recovered_div_clock(recovered_div_clock));

// ==== sim/sfl_framer_model.sv ====
// Framer model that drives the transmit lanes
module sfl_framer_model (
   // Clock and control
   input wire logic ref_clk,
   input wire logic run,
   input wire logic overrun,
   input wire logic [3:0] word,
   // Transmit lanes
   output logic tx_lane_clock = 1'b0,
   output logic [3:0] tx_lane_in = 4'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] ph = 4'h0;
   logic [3:0] next_ph;
   // Overrun drops the low phase to one cycle, outside the contract,
   // so words arrive faster than the buffer drains
   assign next_ph = (ph >= (overrun ? 4'h2 : 4'h7)) ? 4'h0 : ph + 4'h1;
   always @(posedge ref_clk) begin
      if (!run) begin
         // Clock stands still, idle lanes toggle so stale data never looks valid
         ph <= 4'h0;
         tx_lane_clock <= 1'b0;
         tx_lane_in <= ~tx_lane_in;
      end else begin
         ph <= next_ph;
         tx_lane_clock <= (next_ph >= (overrun ? 4'h1 : 4'h4));
         if (next_ph == 4'h0) begin
            tx_lane_in <= word;
         end
      end
   end
endmodule : sfl_framer_model

// ==== sim/sfl_serdes_ctrl_tb_top.sv ====
// Self-checking bench for the serdes control block
module sfl_serdes_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic flush = 1'b0, mult_in = 1'b0, cdr_in = 1'b0, loss_in = 1'b1, pri = 1'b0, sec = 1'b0;
   logic run = 1'b0, overrun = 1'b0, err, pready, pslverr, txc, ovf, txs, oe, coe, rxc;
   logic divc, mult_f, cdr_f, los_f, irq;
   logic [2:0] bits;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [3:0] word = 4'h0, rx_out, tx_in, acc;
   logic [3:0] w [4];
   int n_fail = 0, checks = 0, cyc = 0;
   always #5 ref_clk = ~ref_clk;
   sfl_serdes_ctrl u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_lane_clock(txc), .tx_lane_in(tx_in),
      .buffer_flush_in(flush), .multiplier_locked_in(mult_in), .multiplier_lock_flag(mult_f),
      .tx_overflow(ovf), .tx_serial_out(txs), .primary_serial_in(pri),
      .secondary_serial_in(sec), .recovery_locked_in(cdr_in), .optical_loss_in(loss_in),
      .rx_lane_out(rx_out), .rx_lane_oe(oe), .rx_lane_clock(rxc), .rx_clock_oe(coe),
      .recovered_div_clock(divc), .recovery_lock_flag(cdr_f), .signal_loss_flag(los_f),
      .irq(irq));
   sfl_framer_model u_framer (.ref_clk(ref_clk), .run(run), .overrun(overrun),
      .word(word), .tx_lane_clock(txc), .tx_lane_in(tx_in));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // No own limit: only the bench ceiling ends a hung access
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
      input string what);
      apb(1'b0, a, 32'h0000_0000);
      check(rd & m, e, what);
   endtask : rdchk
   task automatic wait_hi(ref logic s);
      for (int n = 0; n < 1000 && s !== 1'b1; n++) @(posedge ref_clk);
   endtask : wait_hi
   task automatic end_sim;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim
   // Ceiling well above the less than a thousand cycles the tests need
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         check(0, 1, "timeout");
         end_sim;
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      run <= 1'b1;
      flush <= 1'b1;
      repeat (sfl_pkg::POWERUP_FLUSH_CYCLES) @(posedge txc);
      @(posedge ref_clk);
      flush <= 1'b0;
      rdchk(sfl_pkg::CTRL_OFS, 32'h0000_0000, 32'hFFFF_FFFF, "ctrl reset");
      rdchk(sfl_pkg::EVENT_OFS, 32'h0000_0000, 32'hFFFF_FFFF, "event reset");
      rdchk(sfl_pkg::MASK_OFS, 32'h0000_0000, 32'hFFFF_FFFF, "mask reset");
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      check(err, 1'b1, "unmapped error");
      rdchk(12'h010, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped read");
      $display("test registers done");
      for (int v = 0; v < 4; v++) begin
         mult_in <= v[0];
         cdr_in <= v[1];
         repeat (6) @(posedge ref_clk);
         check({cdr_f, mult_f}, v[1:0], "lock flags");
      end
      apb(1'b1, sfl_pkg::CTRL_OFS, 32'h0000_0020);
      rdchk(sfl_pkg::STATUS_OFS, 32'h0000_0038, 32'h0000_003F, "status word");
      $display("test locks done");
      pri <= 1'b1;
      for (int v = 0; v < 4; v++) begin
         loss_in <= v[0];
         apb(1'b1, sfl_pkg::CTRL_OFS, 32'h0000_0002 | (v[1] << 2));
         repeat (12) @(posedge ref_clk);
         check(los_f, (v[0] == v[1]), "loss flag");
         check(rx_out, (v[0] == v[1]) ? 4'h0 : 4'hF, "muted data");
      end
      apb(1'b1, sfl_pkg::CTRL_OFS, 32'h0000_0004);
      repeat (12) @(posedge ref_clk);
      check(rx_out, 4'hF, "no mute");
      loss_in <= 1'b1;
      apb(1'b1, sfl_pkg::CTRL_OFS, 32'h0000_0008);
      repeat (12) @(posedge ref_clk);
      check(rx_out, 4'h0, "secondary input");
      apb(1'b1, sfl_pkg::CTRL_OFS, 32'h0000_0010);
      repeat (3) @(posedge ref_clk);
      check({oe, coe}, 2'b00, "float");
      apb(1'b1, sfl_pkg::CTRL_OFS, 32'h0000_0000);
      repeat (3) @(posedge ref_clk);
      check({oe, coe}, 2'b11, "drive");
      $display("test receive done");
      apb(1'b1, sfl_pkg::EVENT_OFS, 32'h0000_000F);
      apb(1'b1, sfl_pkg::MASK_OFS, 32'h0000_0002);
      loss_in <= 1'b0;
      repeat (8) @(posedge ref_clk);
      check(irq, 1'b1, "irq raised");
      apb(1'b1, sfl_pkg::MASK_OFS, 32'h0000_0000);
      repeat (3) @(posedge ref_clk);
      check(irq, 1'b0, "irq masked");
      apb(1'b1, sfl_pkg::MASK_OFS, 32'h0000_0002);
      apb(1'b1, sfl_pkg::EVENT_OFS, 32'h0000_0002);
      repeat (3) @(posedge ref_clk);
      check(irq, 1'b0, "irq cleared");
      loss_in <= 1'b1;
      $display("test interrupt done");
      overrun <= 1'b1;
      wait_hi(ovf);
      check(ovf, 1'b1, "overflow set");
      overrun <= 1'b0;
      repeat (30) @(posedge ref_clk);
      check(ovf, 1'b1, "overflow held");
      flush <= 1'b1;
      repeat (6) @(posedge ref_clk);
      flush <= 1'b0;
      check(ovf, 1'b0, "manual flush");
      apb(1'b1, sfl_pkg::CTRL_OFS, 32'h0000_0001);
      overrun <= 1'b1;
      wait_hi(ovf);
      check(ovf, 1'b1, "auto overflow seen");
      repeat (3) @(posedge ref_clk);
      check(ovf, 1'b0, "auto flush");
      overrun <= 1'b0;
      apb(1'b1, sfl_pkg::CTRL_OFS, 32'h0000_0000);
      word <= 4'hB;
      wait_hi(txs);
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         bits[2 - i] = txs;
      end
      check(bits, 3'b011, "tx bit order");
      $display("test transmit done");
      pri <= 1'b0;
      // Let stale ones drain out of the synchroniser and shifter
      repeat (8) @(posedge ref_clk);
      for (int k = 0; k < 4; k++) begin
         @(posedge rxc);
         repeat (k + 1) @(posedge ref_clk);
         pri <= 1'b1;
         @(posedge ref_clk);
         pri <= 1'b0;
         acc = 4'h0;
         repeat (3) begin
            @(posedge rxc);
            @(posedge ref_clk);
            acc = acc | rx_out;
         end
         w[k] = acc;
      end
      check(w[0] | w[1] | w[2] | w[3], 4'hF, "all lanes hit");
      for (int k = 0; k < 3; k++) begin
         if (w[k] != 4'h1) check(w[k + 1], w[k] >> 1, "rx bit order");
      end
      $display("test rx order done");
      end_sim;
   end
endmodule : sfl_serdes_ctrl_tb_top
